// ===== dslc_pkg.sv
//==============================================================
// dslc package
//==============================================================
// Contract
// - while latch_load_n is low the converter latch follows the input register.
// - the output code changes in the same cycle the converter latch is updated.
// - after reset the registers hold 8000h when reset_code_select is high, else 0000h.
// - a low on the active-low reset pin resets the device to the selected reset code.
// - number_format_select high means straight binary, low means two's complement.
// - buffer gain is 1 with gain select low and 2 with it high.
// - while power_down_in is high the output is in power-down, tied to ground; here only power_down_out is raised and analog_output_pin keeps its code.
// - bits shift in only while chip select is low; the host keeps it low all frame.
// - the serial data output is released (high impedance) while chip select is high.
// - with serial_out_mode_select high the input register shifts out on the data output.
// - with serial_out_mode_select low the shift register shifts out for daisy chaining.
package dslc_pkg;
    localparam int          DSLC_W          = 16;
    localparam logic [15:0] DSLC_RST_MID    = 16'h8000;
    localparam logic [15:0] DSLC_RST_ZERO   = 16'h0000;
    localparam logic [15:0] DSLC_MSB_FLIP   = 16'h8000;
    localparam logic [4:0]  DSLC_FRAME_BITS = 5'h10;
    localparam logic [1:0]  DSLC_SYNC_RST   = 2'h3;
    typedef enum logic [1:0] {
        DSLC_RUN    = 2'b00,
        DSLC_RESET  = 2'b01,
        DSLC_POWDN  = 2'b10
    } dslc_state_t;
endpackage

// ===== dslc_link.sv
`timescale 1ns/10ps
//==============================================================
// link side: shift register on the serial clock
//==============================================================
module dslc_link (
    // link
    input  wire logic                       sclk,
    input  wire logic                       cs_n,
    input  wire logic                       sdi,
    input  wire logic                       mode_standalone,
    input  wire logic [dslc_pkg::DSLC_W-1:0] load_word,
    // results
    output logic [dslc_pkg::DSLC_W-1:0]      shift_q,
    output logic [4:0]                       count_q,
    output logic                             sdo_q
);
    import dslc_pkg::*;
    logic [DSLC_W-1:0] out_sr_q;
    logic              fresh_q;

    // set while deselected, cleared by the first shift edge of a frame
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            fresh_q <= 1'b1;
        end else begin
            fresh_q <= 1'b0;
        end
    end

    // shift on rising edge, only while selected; count survives cs rise for capture
    always_ff @(posedge sclk) begin
        if (!cs_n) begin
            shift_q <= {shift_q[DSLC_W-2:0], sdi};
            if (fresh_q) begin
                count_q <= 5'h01;
            end else if (count_q != 5'h1f) begin
                count_q <= count_q + 5'h01;
            end
        end
    end

    // readback register loaded at the first edge of a frame
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            out_sr_q <= '0;
        end else if (fresh_q) begin
            out_sr_q <= {load_word[DSLC_W-2:0], 1'b0};
        end else begin
            out_sr_q <= {out_sr_q[DSLC_W-2:0], 1'b0};
        end
    end

    // msb stands before the first edge; clk-side delay gives the host its hold time
    always_comb begin
        if (mode_standalone) begin
            sdo_q = fresh_q ? load_word[DSLC_W-1] : out_sr_q[DSLC_W-1];
        end else begin
            sdo_q = shift_q[DSLC_W-1];
        end
    end
endmodule

// ===== dslc_top.sv
`timescale 1ns/10ps
//==============================================================
// dac serial load control top
//==============================================================
module dslc_top (
    // system
    input  wire logic                        clk,
    input  wire logic                        sys_rst,
    input  wire logic                        clk_en,
    // serial link
    input  wire logic                        sclk,
    input  wire logic                        cs_n,
    input  wire logic                        sdi,
    output logic                             sdo_o,
    output logic                             sdo_oe_n,
    // configuration pins
    input  wire logic                        latch_load_n,
    input  wire logic                        reset_n,
    input  wire logic                        reset_code_select,
    input  wire logic                        number_format_select,
    input  wire logic                        gain_select,
    input  wire logic                        power_down_in,
    input  wire logic                        serial_out_mode_select,
    // converter side
    output logic [dslc_pkg::DSLC_W-1:0]      analog_output_pin,
    output logic [dslc_pkg::DSLC_W-1:0]      input_reg_out,
    output logic                             gain_two,
    output logic                             power_down_out,
    output logic                             output_valid
);
    import dslc_pkg::*;

    //==========================================================
    // pin synchronisers
    //==========================================================
    logic [1:0] cs_sync_q, ld_sync_q, rst_sync_q, rsel_sync_q, fmt_sync_q;
    logic [1:0] gain_sync_q, pd_sync_q, mode_sync_q;
    logic       cs_prev_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cs_sync_q   <= DSLC_SYNC_RST;
            ld_sync_q   <= DSLC_SYNC_RST;
            rst_sync_q  <= DSLC_SYNC_RST;
            fmt_sync_q  <= DSLC_SYNC_RST;
            gain_sync_q <= '0;
            pd_sync_q   <= '0;
            mode_sync_q <= DSLC_SYNC_RST;
            cs_prev_q   <= 1'b1;
        end else if (clk_en) begin
            cs_sync_q   <= {cs_sync_q[0], cs_n};
            ld_sync_q   <= {ld_sync_q[0], latch_load_n};
            rst_sync_q  <= {rst_sync_q[0], reset_n};
            fmt_sync_q  <= {fmt_sync_q[0], number_format_select};
            gain_sync_q <= {gain_sync_q[0], gain_select};
            pd_sync_q   <= {pd_sync_q[0], power_down_in};
            mode_sync_q <= {mode_sync_q[0], serial_out_mode_select};
            cs_prev_q   <= cs_sync_q[1];
        end
    end

    // reset code pin keeps sampling during sys_rst so the first reset load sees it
    always_ff @(posedge clk) begin
        if (clk_en) begin
            rsel_sync_q <= {rsel_sync_q[0], reset_code_select};
        end
    end

    logic cs_s, ld_n_s, rst_n_s, rsel_s, fmt_s, gain_s, pd_s, mode_s, cs_rise;
    assign cs_s    = cs_sync_q[1];
    assign ld_n_s  = ld_sync_q[1];
    assign rst_n_s = rst_sync_q[1];
    assign rsel_s  = rsel_sync_q[1];
    assign fmt_s   = fmt_sync_q[1];
    assign gain_s  = gain_sync_q[1];
    assign pd_s    = pd_sync_q[1];
    assign mode_s  = mode_sync_q[1];
    assign cs_rise = cs_s && !cs_prev_q;

    function automatic logic [DSLC_W-1:0] reset_code(input logic sel);
        reset_code = sel ? DSLC_RST_MID : DSLC_RST_ZERO;
    endfunction

    //==========================================================
    // link domain
    //==========================================================
    logic [DSLC_W-1:0] shift_w;
    logic [4:0]        count_w;
    logic              sdo_w;

    dslc_link u_link (
        .sclk            (sclk),
        .cs_n            (cs_n),
        .sdi             (sdi),
        .mode_standalone (mode_s),
        .load_word       (input_reg_out),
        .shift_q         (shift_w),
        .count_q         (count_w),
        .sdo_q           (sdo_w)
    );

    // shift word is stable while cs is high, so sampling after sync is safe
    logic [DSLC_W-1:0] shift_cap_q;
    logic [4:0]        count_cap_q;
    logic [1:0]        sdo_sync_q;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            shift_cap_q <= '0;
            count_cap_q <= '0;
        end else if (clk_en && cs_s) begin
            shift_cap_q <= shift_w;
            count_cap_q <= count_w;
        end
    end

    //==========================================================
    // control state
    //==========================================================
    dslc_state_t state_q;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= DSLC_RESET;
        end else if (clk_en) begin
            case (state_q)
                DSLC_RUN:   state_q <= !rst_n_s ? DSLC_RESET : (pd_s ? DSLC_POWDN : DSLC_RUN);
                DSLC_RESET: state_q <= rst_n_s ? DSLC_RUN : DSLC_RESET;
                DSLC_POWDN: state_q <= !rst_n_s ? DSLC_RESET : (pd_s ? DSLC_POWDN : DSLC_RUN);
                default:    state_q <= DSLC_RESET;
            endcase
        end
    end

    //==========================================================
    // input register and converter latch
    //==========================================================
    logic cs_rise_q;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cs_rise_q <= 1'b0;
        end else if (clk_en) begin
            cs_rise_q <= cs_rise;
        end
    end

    logic [DSLC_W-1:0] frame_word;
    assign frame_word = fmt_s ? shift_cap_q : (shift_cap_q ^ DSLC_MSB_FLIP);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            input_reg_out <= DSLC_RST_ZERO;
        end else if (clk_en) begin
            if (state_q == DSLC_RESET) begin
                input_reg_out <= reset_code(rsel_s);
            end else if (cs_rise_q && count_cap_q >= DSLC_FRAME_BITS) begin
                input_reg_out <= frame_word;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            analog_output_pin <= DSLC_RST_ZERO;
            output_valid      <= 1'b0;
        end else if (clk_en) begin
            if (state_q == DSLC_RESET) begin
                analog_output_pin <= reset_code(rsel_s);
                output_valid      <= 1'b0;
            end else begin
                output_valid <= 1'b1;
                if (!ld_n_s) begin
                    analog_output_pin <= input_reg_out;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            gain_two       <= 1'b0;
            power_down_out <= 1'b0;
        end else if (clk_en) begin
            gain_two       <= gain_s;
            power_down_out <= (state_q == DSLC_POWDN) || pd_s;
        end
    end

    //==========================================================
    // serial data output
    //==========================================================
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sdo_sync_q <= '0;
            sdo_o      <= 1'b0;
            sdo_oe_n   <= 1'b1;
        end else if (clk_en) begin
            sdo_sync_q <= {sdo_sync_q[0], sdo_w};
            sdo_o      <= sdo_sync_q[1];
            sdo_oe_n   <= cs_s;
        end
    end

    //==========================================================
    // checks
    //==========================================================
    a_hiz_when_desel: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && cs_s |=> sdo_oe_n) else $error("sdo driven while deselected");
    a_latch_transparent: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && !ld_n_s && state_q == DSLC_RUN |=> analog_output_pin == $past(input_reg_out))
        else $error("latch not following input register");
    a_latch_hold: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && ld_n_s && state_q != DSLC_RESET |=> $stable(analog_output_pin))
        else $error("output moved without latch update");
    a_reset_code_mid: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && state_q == DSLC_RESET && rsel_s |=> input_reg_out == 16'h8000)
        else $error("midscale reset code wrong");
    a_reset_code_zero: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && state_q == DSLC_RESET && !rsel_s |=> input_reg_out == 16'h0000)
        else $error("zero reset code wrong");
    a_twos_comp_load: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && state_q != DSLC_RESET && cs_rise_q && count_cap_q >= 5'h10 && !fmt_s
        |=> input_reg_out == ($past(shift_cap_q) ^ 16'h8000)) else $error("msb not inverted");
    a_binary_load: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && state_q != DSLC_RESET && cs_rise_q && count_cap_q >= 5'h10 && fmt_s
        |=> input_reg_out == $past(shift_cap_q)) else $error("binary word altered");
    a_gain_follow: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en |=> gain_two == $past(gain_s)) else $error("gain wrong");
    a_powerdown_flag: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && pd_s |=> power_down_out) else $error("power-down not shown");
    a_no_short_load: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && state_q != DSLC_RESET && cs_rise_q && count_cap_q < 5'h10 && !(!ld_n_s)
        |=> $stable(input_reg_out)) else $error("short frame loaded");
    a_oe_driving: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && !cs_s |=> !sdo_oe_n) else $error("sdo not driven while selected");
    a_valid_in_reset: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && state_q == DSLC_RESET |=> !output_valid) else $error("valid during reset");
    a_reset_latch_mid: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && state_q == DSLC_RESET && rsel_s |=> analog_output_pin == 16'h8000)
        else $error("latch midscale reset code wrong");
    a_reset_hold: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && !rst_n_s |=> state_q == DSLC_RESET) else $error("reset pin not obeyed");
    a_powerdown_enter: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && rst_n_s && pd_s |=> state_q == DSLC_POWDN) else $error("power-down not entered");
    a_powerdown_exit: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && state_q == DSLC_POWDN && rst_n_s && !pd_s |=> state_q == DSLC_RUN)
        else $error("power-down not left");
    a_idle_no_load: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && state_q != DSLC_RESET && !cs_rise_q |=> $stable(input_reg_out))
        else $error("input register moved without frame");
    a_enable_freeze: assert property (@(posedge clk) disable iff (sys_rst)
        !clk_en |=> $stable(input_reg_out) && $stable(analog_output_pin))
        else $error("state moved while disabled");

    c_frame_load: cover property (@(posedge clk) cs_rise_q && count_cap_q == 5'h10);
    c_latch_update: cover property (@(posedge clk) !ld_n_s && state_q == DSLC_RUN);
    c_power_down: cover property (@(posedge clk) state_q == DSLC_POWDN);
    c_daisy_mode: cover property (@(posedge clk) !mode_s && !cs_s);
    c_readback_mode: cover property (@(posedge clk) mode_s && !cs_s);
endmodule

// ===== dslc_host.sv
`timescale 1ns/10ps
//==============================================================
// spi host model, link clock idles low outside frames
//==============================================================
module dslc_host (
    // link
    output logic      sclk,
    output logic      cs_n,
    output logic      sdi,
    input  wire logic sdo
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b0;
        sdi  = 1'b0;
        // a rising select edge at start sets fresh_q and clears out_sr_q; shift_q and count_q stay unset
        #1;
        cs_n = 1'b1;
    end

    // one frame msb first; nbits under 16 makes a short frame
    task automatic send(input logic [15:0] word, input int nbits, input int stretch,
                        output logic [15:0] rx);
        rx   = 16'h0000;
        cs_n = 1'b0;
        #100;
        for (int i = 15; i > 15 - nbits; i--) begin
            sdi = word[i];
            #(62.5 + stretch);
            sclk = 1'b1;
            rx   = {rx[14:0], sdo};
            #(62.5 + stretch);
            sclk = 1'b0;
        end
        #62.5;
        cs_n = 1'b1;
        // released line shows the inverse of its last bit
        sdi  = ~sdi;
    endtask
endmodule

// ===== tb.sv
`timescale 1ns/10ps
//==============================================================
// testbench
//==============================================================
module tb;
    import dslc_pkg::*;
    logic              clk, sys_rst, clk_en, latch_load_n, reset_n, reset_code_select;
    logic              number_format_select, gain_select, power_down_in, serial_out_mode_select;
    logic              sclk, cs_n, sdi, sdo_o, sdo_oe_n, sdo_line, gain_two, power_down_out, output_valid;
    logic [DSLC_W-1:0] analog_output_pin, input_reg_out, rx;
    int                err_count, check_count;

    // released data line shows the inverse of the driven value
    assign sdo_line = sdo_oe_n ? ~sdo_o : sdo_o;

    dslc_top dslc_top_inst (
        .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
        .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n), .latch_load_n(latch_load_n), .reset_n(reset_n),
        .reset_code_select(reset_code_select), .number_format_select(number_format_select),
        .gain_select(gain_select), .power_down_in(power_down_in),
        .serial_out_mode_select(serial_out_mode_select), .analog_output_pin(analog_output_pin),
        .input_reg_out(input_reg_out), .gain_two(gain_two), .power_down_out(power_down_out),
        .output_valid(output_valid)
    );

    dslc_host dslc_host_inst (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo_line));

    always #5 clk = ~clk;

    //==============================================================
    // helpers
    //==============================================================
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic frame(input logic [15:0] w, input int nbits, input int stretch);
        dslc_host_inst.send(w, nbits, stretch, rx);
        wait_clk(8);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    //==============================================================
    // tests
    //==============================================================
    initial begin
        clk = 1'b0;
        sys_rst = 1'b1;
        clk_en = 1'b1;
        latch_load_n = 1'b0;
        reset_n = 1'b1;
        reset_code_select = 1'b1;
        number_format_select = 1'b1;
        gain_select = 1'b0;
        power_down_in = 1'b0;
        serial_out_mode_select = 1'b0;
        err_count = 0;
        check_count = 0;
        wait_clk(4);
        sys_rst = 1'b0;
        wait_clk(10);
        check(input_reg_out, DSLC_RST_MID, "mid reset code");
        check(analog_output_pin, DSLC_RST_MID, "latch after reset");
        check({15'h0, output_valid}, 16'h0001, "valid after reset");
        check({15'h0, sdo_oe_n}, 16'h0001, "data out released");
        $display("test power-on reset done");
        reset_code_select = 1'b0;
        reset_n = 1'b0;
        wait_clk(6);
        reset_n = 1'b1;
        wait_clk(8);
        check(input_reg_out, DSLC_RST_ZERO, "zero reset code");
        check(analog_output_pin, DSLC_RST_ZERO, "latch zero code");
        $display("test reset pin done");
        latch_load_n = 1'b1;
        frame(16'h1234, 16, 0);
        check(input_reg_out, 16'h1234, "binary word stored");
        check(analog_output_pin, DSLC_RST_ZERO, "latch held");
        check({15'h0, sdo_oe_n}, 16'h0001, "released after frame");
        latch_load_n = 1'b0;
        wait_clk(4);
        check(analog_output_pin, 16'h1234, "latch follows");
        frame(16'hffff, 8, 0);
        check(input_reg_out, 16'h1234, "short frame ignored");
        $display("test load and latch done");
        number_format_select = 1'b0;
        wait_clk(4);
        frame(16'h1234, 16, 200);
        check(input_reg_out, 16'h1234 ^ DSLC_MSB_FLIP, "twos complement stored");
        check(analog_output_pin, 16'h1234 ^ DSLC_MSB_FLIP, "latch twos complement");
        serial_out_mode_select = 1'b1;
        wait_clk(4);
        frame(16'h00ff, 16, 0);
        check(rx, 16'h1234 ^ DSLC_MSB_FLIP, "stand-alone readback");
        check(input_reg_out, 16'h80ff, "readback frame stored");
        $display("test format and readback done");
        serial_out_mode_select = 1'b0;
        number_format_select = 1'b1;
        wait_clk(4);
        frame(16'ha5c3, 16, 0);
        frame(16'h5a3c, 16, 0);
        check(rx, 16'ha5c3, "daisy chain pass-through");
        check(input_reg_out, 16'h5a3c, "daisy word stored");
        $display("test daisy chain done");
        for (int g = 1; g >= 0; g--) begin
            gain_select = g[0];
            power_down_in = g[0];
            wait_clk(4);
            check({15'h0, gain_two}, {15'h0, g[0]}, "gain setting");
            check({15'h0, power_down_out}, {15'h0, g[0]}, "power-down status");
        end
        $display("test gain and power-down done");
        print_verdict();
    end

    initial begin
        #200000;
        err_count++;
        $display("Error at %0t: watchdog expired", $time);
        print_verdict();
    end
endmodule
